//--- pkg/qsp_map.svh
// Constants for the burst-of-two double-rate memory port
`ifndef QSP_MAP_SVH
`define QSP_MAP_SVH

// One lane mask covers this many data bits
`define QSP_LANE_W 9
// Data widths of the two configurations
`define QSP_NARROW_DATA_W 18
`define QSP_WIDE_DATA_W 36
// Address widths of the two configurations
`define QSP_NARROW_ADDR_W 20
`define QSP_WIDE_ADDR_W 19
// Write bursts buffered between capture and array
`define QSP_FIFO_DEPTH 32
// Pin clocks tracked for edges: true in, complement in, true out, complement out
`define QSP_PIN_CLOCKS 4
// Flops in front of every pin before logic reads it
`define QSP_SYNC_STAGES 2

`endif

//--- pkg/qsp_pkg.sv
// Types shared by the memory port modules
package qsp_pkg;

	// Read output sequencer, one-hot
	typedef enum logic [2:0] {
		rd_idle = 3'h1,
		rd_second = 3'h2,
		rd_tail = 3'h4
	} qsp_rd_state_type;

endpackage : qsp_pkg

//--- pkg/qsp_fifo_if.sv
// Valid/ready carrier between the port core and its write buffer
`timescale 1ns/100ps

interface qsp_fifo_if #(parameter int WIDTH = 8);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;

	// Filling and draining party
	modport user (
		output push_valid,
		output push_data,
		input push_ready,
		input pop_valid,
		input pop_data,
		output pop_ready
	);

	// The buffer itself
	modport fifo (
		input push_valid,
		input push_data,
		output push_ready,
		output pop_valid,
		output pop_data,
		input pop_ready
	);
endinterface : qsp_fifo_if

//--- core/qsp_fifo.sv
// Parameterised write buffer with valid/ready on both sides
`timescale 1ns/100ps
`include "qsp_map.svh"

module qsp_fifo
	import qsp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = `QSP_FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	qsp_fifo_if.fifo port_if
);
	// Depth must be a power of two: pointers wrap by overflow
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW:0] ONE_COUNT = (PW+1)'(1);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	wire push_fire;
	wire pop_fire;

	// Handshake terms, honest full and empty
	assign port_if.push_ready = (count_r != FULL_COUNT);
	assign port_if.pop_valid = (count_r != '0);
	assign port_if.pop_data = store_r[rd_ptr_r];
	assign push_fire = port_if.push_valid & port_if.push_ready;
	assign pop_fire = port_if.pop_valid & port_if.pop_ready;

	// Storage has no reset, only pointers and fill level do
	always_ff @(posedge clock_in) begin
		if (push_fire) begin
			store_r[wr_ptr_r] <= port_if.push_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + PW'(push_fire);
			rd_ptr_r <= rd_ptr_r + PW'(pop_fire);
			if (push_fire && !pop_fire) begin
				count_r <= count_r + ONE_COUNT;
			end else if (pop_fire && !push_fire) begin
				count_r <= count_r - ONE_COUNT;
			end
		end
	end

	AST_FIFO_PASS_THROUGH: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(push_fire && count_r == '0) |=>
			(port_if.pop_valid && port_if.pop_data == $past(port_if.push_data)))
		else $error("Burst pushed into empty buffer not presented next cycle");

endmodule : qsp_fifo

//--- core/qsp_port.sv
// Device-side logic of a burst-of-two double-rate static memory port
`timescale 1ns/100ps
`include "qsp_map.svh"

module qsp_port
	import qsp_pkg::*;
#(
	parameter bit WIDE = 1'b0,
	parameter int DW = WIDE ? `QSP_WIDE_DATA_W : `QSP_NARROW_DATA_W,
	parameter int AW = WIDE ? `QSP_WIDE_ADDR_W : `QSP_NARROW_ADDR_W,
	parameter int LN = DW / `QSP_LANE_W,
	parameter int FIFO_DEPTH = `QSP_FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic in_clk_in,
	input wire logic in_clk_n_in,
	input wire logic out_clk_in,
	input wire logic out_clk_n_in,
	input wire logic single_clock_mode_in,
	input wire logic store_port_enable_n_in,
	input wire logic fetch_port_enable_n_in,
	input wire logic [AW-1:0] address_in,
	input wire logic [DW-1:0] write_data_in,
	input wire logic [LN-1:0] lane_mask_n_in,
	output logic [DW-1:0] read_data_out,
	output logic read_data_oe_out,
	output logic store_ready_out
);
	localparam int LW = `QSP_LANE_W;
	localparam int NC = `QSP_PIN_CLOCKS;
	localparam int SW = NC + 3 + AW + DW + LN;
	// Buffer entry: write address, second word and masks, first word and masks
	localparam int FW = AW + 2 * DW + 2 * LN;

	// Pin synchroniser chain; first stage is read only by the second
	logic [SW-1:0] sync_meta_r;
	logic [SW-1:0] sync_r;
	logic [NC-1:0] clk_prev_r;
	wire [SW-1:0] pin_bus;
	wire s_k;
	wire s_kn;
	wire s_c;
	wire s_cn;
	wire s_single;
	wire s_store_n;
	wire s_fetch_n;
	wire [AW-1:0] s_addr;
	wire [DW-1:0] s_data;
	wire [LN-1:0] s_mask;
	wire k_rise;
	wire kn_rise;
	wire c_rise;
	wire cn_rise;
	wire oclk_rise;
	wire oclkn_rise;

	// Write capture state
	logic wr_half_r;
	logic [DW-1:0] wr_w0_r;
	logic [LN-1:0] wr_m0_r;
	wire wr_accept;

	// Storage: one array per burst word
	logic [DW-1:0] lower_r [2**AW];
	logic [DW-1:0] upper_r [2**AW];
	wire drain_fire;
	wire [AW-1:0] pop_addr;
	wire [DW-1:0] pop_w0;
	wire [DW-1:0] pop_w1;
	wire [LN-1:0] pop_m0;
	wire [LN-1:0] pop_m1;

	// Read path state
	logic rd_issue_r;
	logic [AW-1:0] rd_addr_r;
	logic [DW-1:0] rd_w0_r;
	logic [DW-1:0] rd_w1_r;
	logic nxt_valid_r;
	logic [DW-1:0] burst_w1_r;
	qsp_rd_state_type state_r;
	qsp_rd_state_type state_nxt;
	logic [DW-1:0] read_data_r;
	logic [DW-1:0] read_data_nxt;
	logic read_oe_r;
	logic read_oe_nxt;
	logic consume;
	logic store_ready_r;

	qsp_fifo_if #(.WIDTH(FW)) wr_fifo_if ();

	qsp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.port_if(wr_fifo_if.fifo)
	);

	// Gather every pin so all of them see the same two-flop delay
	assign pin_bus = {in_clk_in, in_clk_n_in, out_clk_in, out_clk_n_in,
		single_clock_mode_in, store_port_enable_n_in, fetch_port_enable_n_in,
		address_in, write_data_in, lane_mask_n_in};

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_meta_r <= '0;
			sync_r <= '0;
			clk_prev_r <= '0;
		end else begin
			sync_meta_r <= pin_bus;
			sync_r <= sync_meta_r;
			clk_prev_r <= sync_r[SW-1 -: NC];
		end
	end

	// Unpack synchronised pins and find pin clock rises
	assign {s_k, s_kn, s_c, s_cn, s_single, s_store_n, s_fetch_n,
		s_addr, s_data, s_mask} = sync_r;
	assign k_rise = s_k & ~clk_prev_r[3];
	assign kn_rise = s_kn & ~clk_prev_r[2];
	assign c_rise = s_c & ~clk_prev_r[1];
	assign cn_rise = s_cn & ~clk_prev_r[0];
	// Output timing pair, or the input pair in single clock mode
	assign oclk_rise = s_single ? k_rise : c_rise;
	assign oclkn_rise = s_single ? kn_rise : cn_rise;

	// A write is only taken while the buffer can hold its burst
	assign wr_accept = k_rise & ~s_store_n & wr_fifo_if.push_ready;

	// First write word and masks at true input rise
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_half_r <= 1'b0;
			wr_w0_r <= '0;
			wr_m0_r <= '1;
		end else if (k_rise) begin
			wr_half_r <= wr_accept;
			if (wr_accept) begin
				wr_w0_r <= s_data;
				wr_m0_r <= s_mask;
			end
		end else if (kn_rise) begin
			wr_half_r <= 1'b0;
		end
	end

	// Second word, masks and write address at complement rise
	assign wr_fifo_if.push_valid = kn_rise & wr_half_r;
	assign wr_fifo_if.push_data = {s_addr, s_data, s_mask, wr_w0_r, wr_m0_r};

	// Draining stalls while the array serves a read
	assign wr_fifo_if.pop_ready = ~rd_issue_r;
	assign drain_fire = wr_fifo_if.pop_valid & ~rd_issue_r;
	assign {pop_addr, pop_w1, pop_m1, pop_w0, pop_m0} = wr_fifo_if.pop_data;

	// Lane-masked array writes and registered array reads
	always_ff @(posedge clock_in) begin
		if (drain_fire) begin
			for (int i = 0; i < LN; i++) begin
				if (!pop_m0[i]) begin
					lower_r[pop_addr][i*LW +: LW] <= pop_w0[i*LW +: LW];
				end
				if (!pop_m1[i]) begin
					upper_r[pop_addr][i*LW +: LW] <= pop_w1[i*LW +: LW];
				end
			end
		end
		if (rd_issue_r) begin
			rd_w0_r <= lower_r[rd_addr_r];
			rd_w1_r <= upper_r[rd_addr_r];
		end
	end

	// Read address only when the read port is selected
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_issue_r <= 1'b0;
			rd_addr_r <= '0;
		end else begin
			rd_issue_r <= k_rise & ~s_fetch_n;
			if (k_rise && !s_fetch_n) begin
				rd_addr_r <= s_addr;
			end
		end
	end

	// Pending burst flag; a new arrival wins over its consumption
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nxt_valid_r <= 1'b0;
		end else if (rd_issue_r) begin
			nxt_valid_r <= 1'b1;
		end else if (consume) begin
			nxt_valid_r <= 1'b0;
		end
	end

	// Output sequencer: first word on true rise, second on complement rise
	always_comb begin
		state_nxt = state_r;
		read_data_nxt = read_data_r;
		read_oe_nxt = read_oe_r;
		consume = 1'b0;
		case (state_r)
			rd_idle: begin
				read_oe_nxt = 1'b0;
				if (oclk_rise && nxt_valid_r) begin
					read_data_nxt = rd_w0_r;
					read_oe_nxt = 1'b1;
					consume = 1'b1;
					state_nxt = rd_second;
				end
			end
			rd_second: begin
				if (oclkn_rise) begin
					read_data_nxt = burst_w1_r;
					state_nxt = rd_tail;
				end
			end
			rd_tail: begin
				if (oclk_rise) begin
					if (nxt_valid_r) begin
						read_data_nxt = rd_w0_r;
						consume = 1'b1;
						state_nxt = rd_second;
					end else begin
						read_oe_nxt = 1'b0;
						state_nxt = rd_idle;
					end
				end
			end
			default: begin
				read_oe_nxt = 1'b0;
				state_nxt = rd_idle;
			end
		endcase
	end

	// Second word is held apart so a following read cannot overwrite it
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= rd_idle;
			read_data_r <= '0;
			read_oe_r <= 1'b0;
			burst_w1_r <= '0;
			store_ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			read_data_r <= read_data_nxt;
			read_oe_r <= read_oe_nxt;
			store_ready_r <= wr_fifo_if.push_ready;
			if (consume) begin
				burst_w1_r <= rd_w1_r;
			end
		end
	end

	assign read_data_out = read_data_r;
	assign read_data_oe_out = read_oe_r;
	assign store_ready_out = store_ready_r;

	AST_DESELECTED_WRITE: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(k_rise && s_store_n) |=> !wr_half_r)
		else $error("Write started with store enable high");

	AST_WRITE_CAPTURE: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(k_rise && !s_store_n && wr_fifo_if.push_ready) |=>
			(wr_half_r && wr_w0_r == $past(s_data) && wr_m0_r == $past(s_mask)))
		else $error("Accepted write did not capture first word and masks");

	// Unmasked drain must land both burst words at the write address
	AST_DRAIN_WRITES: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(drain_fire && pop_m0 == '0 && pop_m1 == '0) |=>
			(lower_r[$past(pop_addr)] == $past(pop_w0) &&
			upper_r[$past(pop_addr)] == $past(pop_w1)))
		else $error("Drained burst not stored in lower and upper arrays");

	AST_OUTPUT_HOLDS: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(state_r == rd_second && !oclkn_rise) |=> $stable(read_data_out))
		else $error("First burst word changed before complement rise");

	AST_WRITE_ON_COMPLEMENT: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		wr_fifo_if.push_valid |-> (kn_rise && !k_rise && wr_half_r))
		else $error("Write burst pushed outside a complement clock rise");

	AST_READ_ISSUE: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(k_rise && !s_fetch_n) |=> rd_issue_r ##1 nxt_valid_r)
		else $error("Selected read did not reach the pending buffer");

	AST_READ_ADDR_KEPT: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		!(k_rise && !s_fetch_n) |=> $stable(rd_addr_r))
		else $error("Read address moved while read port deselected");

	AST_DRIVE_FIRST: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(state_r == rd_idle && oclk_rise && nxt_valid_r) |=>
			(read_data_oe_out && read_data_out == $past(rd_w0_r)))
		else $error("First burst word not driven on output clock rise");

	AST_DRIVE_SECOND: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(state_r == rd_second && oclkn_rise) |=>
			(read_data_oe_out && read_data_out == $past(burst_w1_r) && state_r == rd_tail))
		else $error("Second burst word not driven on complement rise");

	AST_FLOAT_AFTER_BURST: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(state_r == rd_tail && oclk_rise && !nxt_valid_r) |=> !read_data_oe_out)
		else $error("Outputs still driven after burst with no read pending");

	AST_IDLE_FLOATS: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(state_r == rd_idle && !(oclk_rise && nxt_valid_r)) |=> !read_data_oe_out)
		else $error("Outputs driven with read port idle");

	AST_MASKED_LANE_KEPT: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(drain_fire && pop_m0[1] && !rd_issue_r) |=>
			lower_r[$past(pop_addr)][2*LW-1:LW] == $past(lower_r[pop_addr][2*LW-1:LW]))
		else $error("Masked lane of lower array was changed");

endmodule : qsp_port

//--- tb/qsp_ctrl_model.sv
// Memory controller model driving the port's pin clocks and commands
`timescale 1ns/100ps
`include "qsp_map.svh"

module qsp_ctrl_model #(
	parameter int DW = `QSP_NARROW_DATA_W,
	parameter int AW = `QSP_NARROW_ADDR_W,
	parameter int LN = DW / `QSP_LANE_W
) (
	input wire logic clock_in,
	output logic in_clk_out,
	output logic in_clk_n_out,
	output logic out_clk_out,
	output logic out_clk_n_out,
	output logic store_port_enable_n_out,
	output logic fetch_port_enable_n_out,
	output logic [AW-1:0] address_out,
	output logic [DW-1:0] write_data_out,
	output logic [LN-1:0] lane_mask_n_out
);
	logic [3:0] pin_clk;

	// Pin clocks: 0 true in, 1 complement in, 2 true out, 3 complement out
	assign in_clk_out = pin_clk[0];
	assign in_clk_n_out = pin_clk[1];
	assign out_clk_out = pin_clk[2];
	assign out_clk_n_out = pin_clk[3];

	// Clocks start low so no false rise follows reset
	initial begin
		pin_clk = 4'h0;
		store_port_enable_n_out = 1'b1;
		fetch_port_enable_n_out = 1'b1;
		address_out = '0;
		write_data_out = '0;
		lane_mask_n_out = '1;
	end

	// Wait n cycles, then move just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : step

	// Setup 3 cycles, high 5, low 2: pins are slow next to clock_in
	task automatic pulse(input int which);
		step(3);
		pin_clk[which] = 1'b1;
		step(5);
		pin_clk[which] = 1'b0;
		step(2);
	endtask : pulse

	// Write burst; the bus carries a decoy address at the true rise
	task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] w0,
		input logic [DW-1:0] w1, input logic [LN-1:0] m0, input logic [LN-1:0] m1);
		store_port_enable_n_out = 1'b0;
		address_out = ~a;
		write_data_out = w0;
		lane_mask_n_out = m0;
		pulse(0);
		store_port_enable_n_out = 1'b1;
		address_out = a;
		write_data_out = w1;
		lane_mask_n_out = m1;
		pulse(1);
		// Released lines must not keep their last value
		address_out = ~a;
		write_data_out = ~w1;
		lane_mask_n_out = '1;
		// Let the released values stand one edge before the next command
		step(1);
	endtask : write

	// Full pin cycle with both ports deselected
	task automatic idle(input logic [AW-1:0] a, input logic [DW-1:0] w);
		address_out = a;
		write_data_out = w;
		pulse(0);
		pulse(1);
	endtask : idle

	// Read command on a true input rise
	task automatic read(input logic [AW-1:0] a);
		fetch_port_enable_n_out = 1'b0;
		address_out = a;
		pulse(0);
		fetch_port_enable_n_out = 1'b1;
		address_out = ~a;
	endtask : read
endmodule : qsp_ctrl_model

//--- tb/test_quad_rate_sram_port.sv
// Self-checking bench for the double-rate memory port
`timescale 1ns/100ps
`include "qsp_map.svh"

module test_quad_rate_sram_port;
	localparam int DW = `QSP_NARROW_DATA_W;
	localparam int AW = `QSP_NARROW_ADDR_W;
	localparam int LN = DW / `QSP_LANE_W;
	localparam logic [DW-1:0] D0 = 18'h12345;
	localparam logic [DW-1:0] D1 = 18'h2ABCD;
	logic clock_in;
	logic reset_n_in;
	logic single_clock_mode_in;
	logic in_clk, in_clk_n, out_clk, out_clk_n, store_n, fetch_n;
	logic [AW-1:0] address;
	logic [DW-1:0] write_data;
	logic [DW-1:0] read_data;
	logic [LN-1:0] lane_mask_n;
	logic read_oe, store_ready;
	int miscompares = 0;
	int checks = 0;

	// Small buffer depth makes the buffer pointers wrap within the run
	qsp_port #(.FIFO_DEPTH(4)) uut (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.in_clk_in(in_clk),
		.in_clk_n_in(in_clk_n),
		.out_clk_in(out_clk),
		.out_clk_n_in(out_clk_n),
		.single_clock_mode_in(single_clock_mode_in),
		.store_port_enable_n_in(store_n),
		.fetch_port_enable_n_in(fetch_n),
		.address_in(address),
		.write_data_in(write_data),
		.lane_mask_n_in(lane_mask_n),
		.read_data_out(read_data),
		.read_data_oe_out(read_oe),
		.store_ready_out(store_ready)
	);

	qsp_ctrl_model #(.DW(DW), .AW(AW)) ctrl (
		.clock_in(clock_in),
		.in_clk_out(in_clk),
		.in_clk_n_out(in_clk_n),
		.out_clk_out(out_clk),
		.out_clk_n_out(out_clk_n),
		.store_port_enable_n_out(store_n),
		.fetch_port_enable_n_out(fetch_n),
		.address_out(address),
		.write_data_out(write_data),
		.lane_mask_n_out(lane_mask_n)
	);

	// 20 MHz system clock
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	// Compare and count
	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// Read one address and follow its burst on the active output clocks
	task automatic read_back(input logic [AW-1:0] a, input logic [DW-1:0] e0,
		input logic [DW-1:0] e1);
		int rise;
		rise = single_clock_mode_in ? 0 : 2;
		ctrl.read(a);
		ctrl.pulse(rise);
		check(DW'(read_oe), 18'h00001);
		check(read_data, e0);
		ctrl.pulse(rise + 1);
		check(DW'(read_oe), 18'h00001);
		check(read_data, e1);
		ctrl.pulse(rise);
		check(DW'(read_oe), 18'h00000);
	endtask : read_back

	// Whole burst, both words unmasked
	task automatic t_full_burst;
		ctrl.write(20'h00005, D0, D1, 2'h0, 2'h0);
		read_back(20'h00005, D0, D1);
	endtask : t_full_burst

	// Opposite lanes masked in each word leave the old bits standing
	task automatic t_lanes;
		ctrl.write(20'h00005, 18'h3FFFF, 18'h00000, 2'h2, 2'h1);
		read_back(20'h00005, {D0[17:9], 9'h1FF}, {9'h000, D1[8:0]});
	endtask : t_lanes

	// Deselected ports: nothing stored, nothing driven
	task automatic t_deselect;
		ctrl.idle(20'h00005, 18'h00000);
		ctrl.pulse(2);
		check(DW'(read_oe), 18'h00000);
		read_back(20'h00005, {D0[17:9], 9'h1FF}, {9'h000, D1[8:0]});
	endtask : t_deselect

	// Extreme addresses, written back to back
	task automatic t_edges;
		ctrl.write(20'hFFFFF, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
		ctrl.write(20'h00000, 18'h2D2D2, 18'h1C1C1, 2'h0, 2'h0);
		read_back(20'hFFFFF, 18'h0F0F0, 18'h30303);
		read_back(20'h00000, 18'h2D2D2, 18'h1C1C1);
	endtask : t_edges

	// Output timed from the input clocks in single clock mode
	task automatic t_single;
		single_clock_mode_in = 1'b1;
		ctrl.step(4);
		read_back(20'hFFFFF, 18'h0F0F0, 18'h30303);
		single_clock_mode_in = 1'b0;
		ctrl.step(4);
	endtask : t_single

	// Main sequence
	initial begin
		reset_n_in = 1'b0;
		single_clock_mode_in = 1'b0;
		repeat (4) @(posedge clock_in);
		#1;
		check(DW'(read_oe), 18'h00000);
		check(DW'(store_ready), 18'h00000);
		reset_n_in = 1'b1;
		ctrl.step(4);
		check(DW'(store_ready), 18'h00001);
		t_full_burst();
		t_lanes();
		t_deselect();
		t_edges();
		t_single();
		close_out();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clock_in);
		miscompares++;
		close_out();
	end
endmodule : test_quad_rate_sram_port
